// >>> dhdc_pkg.sv
// Constants and types for the disk head and drive command interpreter
package dhdc_pkg;
  localparam logic [7:0] CMD_RESTORE = 8'h08;
  localparam logic [7:0] CMD_SEEK = 8'h09;
  localparam logic [7:0] CMD_HEAD = 8'h0a;
  localparam logic [7:0] CMD_DRIVE = 8'h0b;
  localparam logic [7:0] CMD_POLL = 8'h0c;
  localparam logic [7:0] CMD_FORMAT = 8'h0d;
  localparam logic [7:0] CMD_BOOT = 8'h0f;
  localparam logic [7:0] ERR_BAD_VALUE = 8'h04;
  localparam logic [7:0] ERR_TIMEOUT = 8'h07;
  localparam logic [7:0] ERR_NOT_SELECTED = 8'h09;
  localparam logic [7:0] ERR_NO_DRIVE = 8'h0b;
  localparam logic [7:0] ERR_STEP_LIMIT = 8'h0e;
  localparam logic [7:0] ERR_UNDERRUN = 8'h0f;
  // Register addresses
  localparam logic [3:0] A_CMD = 4'h0;
  localparam logic [3:0] A_ERROR = 4'h1;
  localparam logic [3:0] A_REASON = 4'h2;
  localparam logic [3:0] A_DRIVE = 4'h3;
  localparam logic [3:0] A_CYL_LO = 4'h4;
  localparam logic [3:0] A_CYL_HI = 4'h5;
  localparam logic [3:0] A_HEAD = 4'h6;
  localparam logic [3:0] A_CUR_LO = 4'h7;
  localparam logic [3:0] A_CUR_HI = 4'h8;
  localparam logic [3:0] A_STATUS = 4'h9;
  localparam logic [3:0] A_TYPE = 4'ha;
  localparam logic [3:0] A_NCYL_LO = 4'hb;
  localparam logic [3:0] A_NCYL_HI = 4'hc;
  localparam logic [3:0] A_NHEADS = 4'hd;
  localparam logic [3:0] A_NSECT = 4'he;
  localparam logic [3:0] A_BUFIDX = 4'hf;
  // Drive type byte fields
  localparam int DT_EXISTS = 0;
  localparam int DT_POLL = 1;
  localparam int DT_SEEKC = 2;
  // Format table layout
  localparam logic [8:0] FMT_TABLE_BASE = 9'h080;
  localparam logic [8:0] FMT_CMD_BYTES = 9'h008;
  localparam int FMT_MAX_BYTES = 384;
  // Boot workspace base in words
  localparam logic [15:0] BOOT_WS_BASE = 16'h0169;
  // Timing
  localparam int CLK_HZ = 25000000;
  localparam int READY_TIMEOUT_S = 1;
  localparam int READY_TIMEOUT_CYC = CLK_HZ * READY_TIMEOUT_S;
  localparam int STEP_PULSE_US = 10;
  localparam int STEP_PULSE_CYC = (STEP_PULSE_US * CLK_HZ + 999999) / 1000000;
  typedef enum logic [3:0] {
    DHDC_IDLE = 4'b0000,
    DHDC_SELECT = 4'b0001,
    DHDC_HEAD = 4'b0011,
    DHDC_STEP = 4'b0010,
    DHDC_WAIT = 4'b0110,
    DHDC_FORMAT = 4'b0111,
    DHDC_DONE = 4'b0101,
    DHDC_HALT = 4'b0100
  } dhdc_state_e;
endpackage : dhdc_pkg

// >>> dhdc_stepper.sv
// Head step pulse generator with direction latch and done strobe
`timescale 1ns/1ps
module dhdc_stepper (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  // Control
  input wire logic go_in,
  input wire logic inward_in,
  // Status
  output logic busy_out,
  output logic done_out,
  // Drive pins
  output logic step_out,
  output logic step_direction_inward_out
);
  // Two pulse widths must fit, so the count is wider than a byte
  localparam logic [9:0] PULSE = 10'(dhdc_pkg::STEP_PULSE_CYC);
  logic [9:0] cnt;
  logic [9:0] next_cnt;
  logic dir;
  logic next_dir;
  logic done;
  logic next_done;
  always_comb
  begin
    next_cnt = cnt;
    next_dir = dir;
    next_done = 1'b0;
    if (cnt != 10'h000)
    begin
      next_cnt = cnt - 10'h001;
      next_done = (cnt == 10'h001);
    end
    else if (go_in)
    begin
      next_dir = inward_in;
      next_cnt = PULSE + PULSE;
    end
  end
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cnt <= 10'h000;
      dir <= 1'b0;
      done <= 1'b0;
    end
    else if (clk_en_in)
    begin
      cnt <= next_cnt;
      dir <= next_dir;
      done <= next_done;
    end
  end
  // Direction settles one cycle before the pulse rises, then holds
  assign step_out = (cnt > PULSE) && (cnt != PULSE + PULSE);
  assign step_direction_inward_out = dir;
  assign busy_out = (cnt != 10'h000);
  assign done_out = done;
endmodule : dhdc_stepper

// >>> dhdc_timer.sv
// One second ready-wait timer
`timescale 1ns/1ps
module dhdc_timer #(
  parameter int TIMEOUT_CYC = dhdc_pkg::READY_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  // Control
  input wire logic run_in,
  // Status
  output logic expired_out
);
  logic [24:0] cnt;
  logic [24:0] next_cnt;
  always_comb
  begin
    next_cnt = 25'h0000000;
    if (run_in)
    begin
      next_cnt = (cnt > 25'(TIMEOUT_CYC)) ? cnt : cnt + 25'h0000001;
    end
  end
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cnt <= 25'h0000000;
    end
    else if (clk_en_in)
    begin
      cnt <= next_cnt;
    end
  end
  // More than the limit must pass, hence strictly greater
  assign expired_out = run_in && (cnt > 25'(TIMEOUT_CYC));
endmodule : dhdc_timer

// >>> dhdc_core.sv
// Command interpreter for head positioning and drive management
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
module dhdc_core #(
  parameter int TIMEOUT_CYC = dhdc_pkg::READY_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  // Register port
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Drive pins
  input wire logic track_zero_pin_in,
  input wire logic [3:0] drive_ready_in,
  output logic [3:0] drive_sel_out,
  output logic [3:0] head_sel_out,
  output logic step_out,
  output logic step_direction_inward_out,
  output logic error_pin_out,
  // Sector buffer write port
  output logic buf_we_out,
  output logic [8:0] buf_addr_out,
  output logic [7:0] buf_wdata_out,
  // Boot hand-off
  output logic boot_start_out,
  output logic [15:0] boot_entry_out,
  output logic [15:0] boot_ws_out
);
  // Per-drive parameter file: type, cylinders, heads, cylinder pos
  logic [7:0] pf_type [4];
  logic [15:0] pf_ncyl [4];
  logic [7:0] pf_nheads [4];
  logic [7:0] pf_cur [4][2];
  logic [7:0] drive, cyl_lo, cyl_hi, head, err, reason, nsect, bufidx;
  logic [7:0] type_w, nheads_w, ncyl_lo, ncyl_hi, cur_lo, cur_hi, cur_drive;
  logic [7:0] entry_lo, entry_hi, ws_lo, ws_hi;
  dhdc_pkg::dhdc_state_e st, next_st;
  logic [7:0] cmd, next_cmd;
  logic [15:0] steps, next_steps;
  logic phase, next_phase;
  logic [8:0] fidx, next_fidx;
  logic [1:0] pidx, next_pidx;
  logic step_go, step_busy, step_done, tmo, wait_run;
  logic [7:0] rdata, next_rdata;
  logic halted;

  function automatic logic disk_cmd(input logic [7:0] c);
    disk_cmd = (c == dhdc_pkg::CMD_RESTORE) || (c == dhdc_pkg::CMD_SEEK) ||
               (c == dhdc_pkg::CMD_POLL) || (c == dhdc_pkg::CMD_FORMAT);
  endfunction : disk_cmd

  function automatic logic [7:0] set_err(input logic [7:0] cur, input logic [7:0] code);
    set_err = (cur == 8'h00) ? code : cur;
  endfunction : set_err

  dhdc_stepper u_step (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .clk_en_in(clk_en_in),
    .go_in(step_go),
    .inward_in(next_phase),
    .busy_out(step_busy),
    .done_out(step_done),
    .step_out(step_out),
    .step_direction_inward_out(step_direction_inward_out)
  );
  dhdc_timer #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_tmr (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .clk_en_in(clk_en_in),
    .run_in(wait_run),
    .expired_out(tmo)
  );

  logic [15:0] cur_cyl, tgt_cyl;
  logic [1:0] di;
  logic drv_ok;
  logic [7:0] sel_type;
  logic [8:0] fmt_end;
  assign cur_cyl = {cur_hi, cur_lo};
  // Reselecting the live drive must use the working copy, not the stale file
  assign sel_type = (drive == cur_drive) ? type_w : pf_type[di];
  assign tgt_cyl = {cyl_hi, cyl_lo};
  assign di = 2'(drive - 8'h01);
  assign drv_ok = (drive >= 8'h01) && (drive <= 8'h04);
  assign wait_run = (st == dhdc_pkg::DHDC_WAIT);
  assign halted = (st == dhdc_pkg::DHDC_HALT);

  // Command sequencer; registers written directly only while idle
  logic [7:0] n_err, n_reason, n_drive, n_head, n_cur_lo, n_cur_hi, n_cdrv;
  logic ld_file;
  always_comb
  begin
    next_st = st;
    next_cmd = cmd;
    next_steps = steps;
    next_phase = phase;
    next_fidx = fidx;
    next_pidx = pidx;
    n_err = err;
    n_reason = reason;
    n_drive = drive;
    n_head = head;
    n_cur_lo = cur_lo;
    n_cur_hi = cur_hi;
    n_cdrv = cur_drive;
    ld_file = 1'b0;
    step_go = 1'b0;
    case (st)
      dhdc_pkg::DHDC_IDLE:
      begin
        if (wr_in && addr_in == dhdc_pkg::A_CMD)
        begin
          next_cmd = wdata_in;
          next_steps = 16'h0000;
          next_pidx = 2'd0;
          if (wdata_in == dhdc_pkg::CMD_BOOT)
          begin
            if (err != 8'h00 || {ws_hi, ws_lo} > dhdc_pkg::BOOT_WS_BASE + 16'({bufidx, 6'h00}))
              next_st = dhdc_pkg::DHDC_HALT;
            else
              next_st = dhdc_pkg::DHDC_DONE;
          end
          else if (disk_cmd(wdata_in) && err != 8'h00)
            next_st = dhdc_pkg::DHDC_IDLE;
          else if (wdata_in == dhdc_pkg::CMD_POLL)
            next_st = dhdc_pkg::DHDC_WAIT;
          else if (wdata_in == dhdc_pkg::CMD_HEAD)
            next_st = dhdc_pkg::DHDC_HEAD;
          else if (wdata_in == dhdc_pkg::CMD_DRIVE || disk_cmd(wdata_in))
            next_st = dhdc_pkg::DHDC_SELECT;
        end
      end
      dhdc_pkg::DHDC_SELECT:
      begin
        if (drive > 8'h04)
        begin
          n_err = set_err(err, dhdc_pkg::ERR_BAD_VALUE);
          n_reason = (err == 8'h00) ? {4'h0, dhdc_pkg::A_DRIVE} : reason;
          n_cdrv = 8'h00;
          next_st = dhdc_pkg::DHDC_IDLE;
        end
        else
        begin
          ld_file = 1'b1;
          n_cdrv = drive;
          next_phase = 1'b1;
          if (cmd == dhdc_pkg::CMD_DRIVE)
            next_st = dhdc_pkg::DHDC_IDLE;
          else if (drive == 8'h00)
          begin
            n_err = dhdc_pkg::ERR_NOT_SELECTED;
            n_reason = 8'h00;
            next_st = dhdc_pkg::DHDC_IDLE;
          end
          else if (!sel_type[dhdc_pkg::DT_EXISTS])
          begin
            n_err = dhdc_pkg::ERR_NO_DRIVE;
            n_reason = 8'h00;
            next_st = dhdc_pkg::DHDC_IDLE;
          end
          else if (cmd == dhdc_pkg::CMD_FORMAT)
            next_st = dhdc_pkg::DHDC_HEAD;
          else
            next_st = dhdc_pkg::DHDC_STEP;
          // Restore starts inward only when on track zero, never a negative track
          next_phase = (cmd == dhdc_pkg::CMD_RESTORE) ? track_zero_pin_in : 1'b0;
        end
      end
      dhdc_pkg::DHDC_HEAD:
      begin
        if (head >= nheads_w)
        begin
          n_err = set_err(err, dhdc_pkg::ERR_BAD_VALUE);
          n_reason = (err == 8'h00) ? {4'h0, dhdc_pkg::A_HEAD} : reason;
          next_st = dhdc_pkg::DHDC_IDLE;
        end
        else
          next_st = (cmd == dhdc_pkg::CMD_FORMAT) ? dhdc_pkg::DHDC_STEP : dhdc_pkg::DHDC_IDLE;
      end
      dhdc_pkg::DHDC_STEP:
      begin
        if (!step_busy && !step_done)
        begin
          if (cmd == dhdc_pkg::CMD_RESTORE)
          begin
            if (phase && !track_zero_pin_in)
              next_phase = 1'b0;
            else if (!phase && track_zero_pin_in)
            begin
              n_cur_lo = 8'h00;
              n_cur_hi = 8'h00;
              next_st = dhdc_pkg::DHDC_DONE;
            end
            else if (steps >= {ncyl_hi, ncyl_lo})
            begin
              n_err = dhdc_pkg::ERR_STEP_LIMIT;
              n_reason = {7'h00, phase};
              next_st = dhdc_pkg::DHDC_IDLE;
            end
            else
            begin
              step_go = 1'b1;
              next_steps = steps + 16'h0001;
            end
          end
          else if (tgt_cyl >= {ncyl_hi, ncyl_lo})
          begin
            n_err = dhdc_pkg::ERR_BAD_VALUE;
            n_reason = {4'h0, dhdc_pkg::A_CYL_LO};
            next_st = dhdc_pkg::DHDC_IDLE;
          end
          else if (cur_cyl == tgt_cyl)
          begin
            // Seek-complete drives return now so others can seek too; format always waits for ready
            if (cmd == dhdc_pkg::CMD_FORMAT)
              next_st = dhdc_pkg::DHDC_WAIT;
            else if (type_w[dhdc_pkg::DT_SEEKC])
              next_st = dhdc_pkg::DHDC_DONE;
            else
              next_st = dhdc_pkg::DHDC_WAIT;
          end
          else
          begin
            next_phase = (tgt_cyl > cur_cyl);
            step_go = 1'b1;
            {n_cur_hi, n_cur_lo} = (tgt_cyl > cur_cyl) ? cur_cyl + 16'h0001 : cur_cyl - 16'h0001;
          end
        end
      end
      dhdc_pkg::DHDC_WAIT:
      begin
        if (cmd == dhdc_pkg::CMD_POLL && drive == 8'h00)
        begin
          next_pidx = pidx + 2'd1;
          if (pf_type[pidx][dhdc_pkg::DT_POLL] && drive_ready_in[pidx])
          begin
            n_drive = {6'h00, pidx} + 8'h01;
            next_st = dhdc_pkg::DHDC_SELECT;
            next_cmd = dhdc_pkg::CMD_DRIVE;
          end
          else if (tmo)
          begin
            n_drive = {6'h00, pidx} + 8'h01;
            n_err = dhdc_pkg::ERR_TIMEOUT;
            n_reason = 8'h00;
            next_st = dhdc_pkg::DHDC_IDLE;
          end
        end
        else if (!drv_ok)
        begin
          n_err = dhdc_pkg::ERR_BAD_VALUE;
          n_reason = {4'h0, dhdc_pkg::A_DRIVE};
          next_st = dhdc_pkg::DHDC_IDLE;
        end
        else if (drive_ready_in[di])
          next_st = (cmd == dhdc_pkg::CMD_FORMAT) ? dhdc_pkg::DHDC_FORMAT : dhdc_pkg::DHDC_DONE;
        else if (tmo)
        begin
          n_err = dhdc_pkg::ERR_TIMEOUT;
          n_reason = 8'h00;
          next_st = dhdc_pkg::DHDC_IDLE;
        end
      end
      dhdc_pkg::DHDC_FORMAT:
      begin
        // Command bytes then one interleave byte per sector up to 128 sectors, 256 bytes above that, left in buffer
        next_fidx = fidx + 9'h001;
        if (fidx + 9'h001 >= fmt_end)
        begin
          next_fidx = 9'h000;
          next_st = dhdc_pkg::DHDC_DONE;
        end
      end
      dhdc_pkg::DHDC_DONE:
        next_st = (cmd == dhdc_pkg::CMD_BOOT) ? dhdc_pkg::DHDC_HALT : dhdc_pkg::DHDC_IDLE;
      dhdc_pkg::DHDC_HALT:
        next_st = dhdc_pkg::DHDC_HALT;
      default:
        next_st = dhdc_pkg::DHDC_IDLE;
    endcase
  end

  assign fmt_end = (nsect > 8'h80) ? 9'(dhdc_pkg::FMT_MAX_BYTES)
                   : dhdc_pkg::FMT_TABLE_BASE + {1'b0, nsect};
  // Track from cylinder/head, or low logical sector when logical bit set
  logic logical_bit;
  assign logical_bit = type_w[7];
  always_comb
  begin
    buf_we_out = (st == dhdc_pkg::DHDC_FORMAT);
    buf_addr_out = fidx;
    if (fidx < dhdc_pkg::FMT_CMD_BYTES)
      buf_wdata_out = (fidx[0]) ? (logical_bit ? bufidx : head) : cyl_lo;
    else if (fidx < dhdc_pkg::FMT_TABLE_BASE)
      buf_wdata_out = 8'h00;
    else
      buf_wdata_out = 8'(fidx - dhdc_pkg::FMT_TABLE_BASE) + 8'h01;
  end

  // Register writes and read data
  always_comb
  begin
    next_rdata = 8'h00;
    case (addr_in)
      dhdc_pkg::A_ERROR: next_rdata = err;
      dhdc_pkg::A_REASON: next_rdata = reason;
      dhdc_pkg::A_DRIVE: next_rdata = drive;
      dhdc_pkg::A_CYL_LO: next_rdata = cyl_lo;
      dhdc_pkg::A_CYL_HI: next_rdata = cyl_hi;
      dhdc_pkg::A_HEAD: next_rdata = head;
      dhdc_pkg::A_CUR_LO: next_rdata = cur_lo;
      dhdc_pkg::A_CUR_HI: next_rdata = cur_hi;
      dhdc_pkg::A_STATUS: next_rdata = {4'h0, st};
      dhdc_pkg::A_TYPE: next_rdata = type_w;
      dhdc_pkg::A_NCYL_LO: next_rdata = ncyl_lo;
      dhdc_pkg::A_NCYL_HI: next_rdata = ncyl_hi;
      dhdc_pkg::A_NHEADS: next_rdata = nheads_w;
      dhdc_pkg::A_NSECT: next_rdata = nsect;
      dhdc_pkg::A_BUFIDX: next_rdata = bufidx;
      default: next_rdata = 8'h00;
    endcase
    if (!rd_in)
      next_rdata = 8'h00;
  end

  logic hw;
  assign hw = wr_in && (st == dhdc_pkg::DHDC_IDLE);
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st <= dhdc_pkg::DHDC_IDLE;
      {cmd, steps, phase, fidx, pidx, rdata} <= '0;
      {err, reason, drive, cur_drive, cyl_lo, cyl_hi, head, cur_lo, cur_hi} <= '0;
      {type_w, ncyl_lo, ncyl_hi, nheads_w, nsect, bufidx} <= '0;
      {entry_lo, entry_hi, ws_lo, ws_hi} <= '0;
      for (int i = 0; i < 4; i++)
      begin
        pf_type[i] <= 8'h00;
        pf_ncyl[i] <= 16'h0000;
        pf_nheads[i] <= 8'h00;
        pf_cur[i][0] <= 8'h00;
        pf_cur[i][1] <= 8'h00;
      end
    end
    else if (clk_en_in)
    begin
      st <= next_st;
      cmd <= next_cmd;
      steps <= next_steps;
      phase <= next_phase;
      fidx <= next_fidx;
      pidx <= next_pidx;
      rdata <= next_rdata;
      err <= (hw && addr_in == dhdc_pkg::A_ERROR) ? wdata_in : n_err;
      reason <= (hw && addr_in == dhdc_pkg::A_REASON) ? wdata_in : n_reason;
      drive <= (hw && addr_in == dhdc_pkg::A_DRIVE) ? wdata_in : n_drive;
      cur_drive <= n_cdrv;
      cur_lo <= n_cur_lo;
      cur_hi <= n_cur_hi;
      if (hw && addr_in == dhdc_pkg::A_CYL_LO) cyl_lo <= wdata_in;
      if (hw && addr_in == dhdc_pkg::A_CYL_HI) cyl_hi <= wdata_in;
      if (hw && addr_in == dhdc_pkg::A_HEAD) head <= wdata_in;
      if (hw && addr_in == dhdc_pkg::A_TYPE) type_w <= wdata_in;
      if (hw && addr_in == dhdc_pkg::A_NCYL_LO) ncyl_lo <= wdata_in;
      if (hw && addr_in == dhdc_pkg::A_NCYL_HI) ncyl_hi <= wdata_in;
      if (hw && addr_in == dhdc_pkg::A_NHEADS) nheads_w <= wdata_in;
      if (hw && addr_in == dhdc_pkg::A_NSECT) nsect <= wdata_in;
      if (hw && addr_in == dhdc_pkg::A_BUFIDX) bufidx <= wdata_in;
      // Boot entry and workspace share the cylinder and cylinder-count pairs
      entry_lo <= cyl_lo;
      entry_hi <= cyl_hi;
      ws_lo <= ncyl_lo;
      ws_hi <= ncyl_hi;
      if (ld_file)
      begin
        if (cur_drive != 8'h00)
        begin
          pf_type[2'(cur_drive - 8'h01)] <= type_w;
          pf_ncyl[2'(cur_drive - 8'h01)] <= {ncyl_hi, ncyl_lo};
          pf_nheads[2'(cur_drive - 8'h01)] <= nheads_w;
          pf_cur[2'(cur_drive - 8'h01)][0] <= cur_lo;
          pf_cur[2'(cur_drive - 8'h01)][1] <= cur_hi;
        end
        if (drive != 8'h00 && drive != cur_drive)
        begin
          type_w <= pf_type[di];
          {ncyl_hi, ncyl_lo} <= pf_ncyl[di];
          nheads_w <= pf_nheads[di];
          cur_lo <= pf_cur[di][0];
          cur_hi <= pf_cur[di][1];
        end
      end
    end
  end

  assign rdata_out = rdata;
  assign error_pin_out = halted && (err != 8'h00 || cmd == dhdc_pkg::CMD_BOOT) &&
                         (err != 8'h00);
  assign drive_sel_out = (cur_drive == 8'h00 || cur_drive > 8'h04) ? 4'h0
                         : 4'(4'h1 << (cur_drive - 8'h01));
  assign head_sel_out = head[3:0];
  // Boot start on an error-free halt; entry from the cylinder pair, workspace from the buffer index
  assign boot_start_out = halted && (err == 8'h00);
  assign boot_entry_out = {entry_hi, entry_lo};
  assign boot_ws_out = dhdc_pkg::BOOT_WS_BASE + 16'({bufidx, 6'h00});
endmodule : dhdc_core

// >>> dhdc_core_assertions.sv
// Port checker for the head and drive command interpreter
`timescale 1ns/1ps
module dhdc_core_assertions #(
  parameter int TIMEOUT_CYC = 200
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // Watched outputs
  input wire logic [3:0] drive_sel_out,
  input wire logic step_out,
  input wire logic step_direction_inward_out,
  input wire logic error_pin_out,
  input wire logic buf_we_out,
  input wire logic [8:0] buf_addr_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  a_sel_one_hot: assert property ($onehot0(drive_sel_out))
    else $error("drive select not one-hot");
  a_step_needs_drive: assert property (step_out |-> drive_sel_out != 4'h0)
    else $error("step with no drive selected");
  // Direction may only move between pulses, never inside one
  a_dir_steady: assert property
    (step_out && $past(step_out) |-> $stable(step_direction_inward_out)) else $error("dir moved");
  a_buf_bound: assert property (buf_we_out |-> buf_addr_out < 9'h180)
    else $error("format write past table");
  a_format_sel: assert property (buf_we_out |-> drive_sel_out != 4'h0)
    else $error("format without drive");
  a_halt_sticky: assert property (error_pin_out |=> error_pin_out)
    else $error("error pin dropped");
  a_halt_still: assert property (error_pin_out |=> !step_out && !buf_we_out)
    else $error("activity after halt");
  a_halt_sel: assert property (error_pin_out |=> $stable(drive_sel_out))
    else $error("select moved after halt");
  c_step: cover property ($rose(step_out));
  c_fmt: cover property (buf_we_out);
  c_halt: cover property ($rose(error_pin_out));
endmodule : dhdc_core_assertions
bind dhdc_core dhdc_core_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in), .drive_sel_out(drive_sel_out),
  .step_out(step_out), .step_direction_inward_out(step_direction_inward_out),
  .error_pin_out(error_pin_out), .buf_we_out(buf_we_out), .buf_addr_out(buf_addr_out)
);

// >>> dhdc_drive_model.sv
// Behavioural head positioner of one disk drive
`timescale 1ns/1ps
module dhdc_drive_model (
  // Drive pins
  input wire logic step_in,
  input wire logic inward_in,
  input wire logic stuck_in,
  output logic track_zero_out
);
  int cyl = 0;
  int inward_steps = 0;
  // A stuck sensor never sees track zero, which forces the step limit
  assign track_zero_out = cyl == 0 && !stuck_in;
  // Heads move on the leading edge; outward steps end at the end stop
  always @(posedge step_in)
    if (inward_in)
    begin
      cyl++;
      inward_steps++;
    end
    else if (cyl > 0)
      cyl--;
endmodule : dhdc_drive_model

// >>> dhdc_core_tb.sv
// Self-checking bench for the head and drive command interpreter
`timescale 1ns/1ps
module dhdc_core_tb;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [3:0] drive_ready_in = 4'h1;
  logic stuck = 1'b0;
  logic [7:0] rdata_out;
  logic [3:0] drive_sel_out;
  logic [3:0] head_sel_out;
  logic [8:0] buf_addr_out;
  logic track_zero, step_out, step_inward, error_pin_out, buf_we_out;
  int err_count = 0;
  int checked = 0;
  int fmt_writes = 0;
  int cyl;
  int n;
  always #20 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in)
    if (buf_we_out === 1'b1 && buf_addr_out >= 9'h080) fmt_writes++;
  dhdc_core #(.TIMEOUT_CYC(200)) u_dut (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .clk_en_in(1'b1),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .track_zero_pin_in(track_zero), .drive_ready_in(drive_ready_in),
    .drive_sel_out(drive_sel_out), .head_sel_out(head_sel_out), .step_out(step_out),
    .step_direction_inward_out(step_inward), .error_pin_out(error_pin_out),
    .buf_we_out(buf_we_out), .buf_addr_out(buf_addr_out), .buf_wdata_out(),
    .boot_start_out(), .boot_entry_out(), .boot_ws_out()
  );
  dhdc_drive_model u_drv (
    .step_in(step_out), .inward_in(step_inward), .stuck_in(stuck), .track_zero_out(track_zero)
  );
  task automatic complete_run();
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Idle cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
    @(posedge core_clk_in);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
    @(posedge core_clk_in);
  endtask : rd
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rdchk
  task automatic cmd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] c);
    logic [7:0] s;
    wr(a, d);
    wr(dhdc_pkg::A_CMD, c);
    for (int i = 0; i < 8000; i++)
    begin
      rd(dhdc_pkg::A_STATUS, s);
      if (s === 8'h00) return;
    end
    err_count++;
    complete_run();
  endtask : cmd
  initial
  begin
    cyl = $urandom(19);
    repeat (10) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    @(posedge core_clk_in);
    cmd(dhdc_pkg::A_DRIVE, 8'h01, dhdc_pkg::CMD_DRIVE);
    chk({4'h0, drive_sel_out}, 8'h01);
    wr(dhdc_pkg::A_TYPE, 8'h07);
    wr(dhdc_pkg::A_NCYL_LO, 8'h14);
    wr(dhdc_pkg::A_NCYL_HI, 8'h00);
    wr(dhdc_pkg::A_NHEADS, 8'h04);
    wr(dhdc_pkg::A_NSECT, 8'h08);
    cmd(dhdc_pkg::A_HEAD, 8'h04, dhdc_pkg::CMD_HEAD);
    rdchk(dhdc_pkg::A_ERROR, dhdc_pkg::ERR_BAD_VALUE);
    wr(dhdc_pkg::A_ERROR, 8'h00);
    n = $urandom_range(3);
    cmd(dhdc_pkg::A_HEAD, 8'(n), dhdc_pkg::CMD_HEAD);
    rdchk(dhdc_pkg::A_ERROR, 8'h00);
    chk({4'h0, head_sel_out}, 8'(n));
    cyl = $urandom_range(15, 1);
    wr(dhdc_pkg::A_CYL_HI, 8'h00);
    cmd(dhdc_pkg::A_CYL_LO, 8'(cyl), dhdc_pkg::CMD_SEEK);
    rdchk(dhdc_pkg::A_CUR_LO, 8'(cyl));
    chk(8'(u_drv.cyl), 8'(cyl));
    cmd(dhdc_pkg::A_ERROR, 8'h00, dhdc_pkg::CMD_RESTORE);
    rdchk(dhdc_pkg::A_CUR_LO, 8'h00);
    chk(8'(u_drv.cyl), 8'h00);
    // From track zero one inward step is enough to leave it
    n = u_drv.inward_steps;
    cmd(dhdc_pkg::A_ERROR, 8'h00, dhdc_pkg::CMD_RESTORE);
    chk(8'(u_drv.inward_steps - n), 8'h01);
    chk(8'(u_drv.cyl), 8'h00);
    stuck <= 1'b1;
    cmd(dhdc_pkg::A_ERROR, 8'h00, dhdc_pkg::CMD_RESTORE);
    rdchk(dhdc_pkg::A_ERROR, dhdc_pkg::ERR_STEP_LIMIT);
    rdchk(dhdc_pkg::A_REASON, 8'h00);
    cmd(dhdc_pkg::A_CYL_LO, 8'h03, dhdc_pkg::CMD_SEEK);
    chk(8'(u_drv.cyl), 8'h00);
    rdchk(dhdc_pkg::A_ERROR, dhdc_pkg::ERR_STEP_LIMIT);
    stuck <= 1'b0;
    drive_ready_in <= 4'h0;
    wr(dhdc_pkg::A_ERROR, 8'h00);
    cmd(dhdc_pkg::A_DRIVE, 8'h01, dhdc_pkg::CMD_POLL);
    rdchk(dhdc_pkg::A_ERROR, dhdc_pkg::ERR_TIMEOUT);
    drive_ready_in <= 4'h1;
    wr(dhdc_pkg::A_ERROR, 8'h00);
    cmd(dhdc_pkg::A_DRIVE, 8'h00, dhdc_pkg::CMD_POLL);
    rdchk(dhdc_pkg::A_DRIVE, 8'h01);
    cmd(dhdc_pkg::A_DRIVE, 8'h01, dhdc_pkg::CMD_FORMAT);
    chk(8'(fmt_writes), 8'h08);
    rdchk(dhdc_pkg::A_ERROR, 8'h00);
    chk({4'h0, drive_sel_out}, 8'h01);
    cmd(dhdc_pkg::A_DRIVE, 8'h00, dhdc_pkg::CMD_DRIVE);
    chk({4'h0, drive_sel_out}, 8'h00);
    // Boot never returns to idle, so no status wait here
    wr(dhdc_pkg::A_ERROR, dhdc_pkg::ERR_NOT_SELECTED);
    wr(dhdc_pkg::A_CMD, dhdc_pkg::CMD_BOOT);
    chk({7'h0, error_pin_out}, 8'h01);
    rdchk(dhdc_pkg::A_STATUS, {4'h0, dhdc_pkg::DHDC_HALT});
    wr(dhdc_pkg::A_DRIVE, 8'h01);
    wr(dhdc_pkg::A_CMD, dhdc_pkg::CMD_DRIVE);
    chk({4'h0, drive_sel_out}, 8'h00);
    complete_run();
  end
endmodule : dhdc_core_tb
